// [rtl/qcc_params.svh]
`ifndef QCC_PARAMS_SVH
`define QCC_PARAMS_SVH

`define QCC_ADDR_W 20
// register indices; byte address is four times the index
`define QCC_IDX_STAT 20'h00094
`define QCC_IDX_AB 20'h0A030
`define QCC_IDX_CD 20'h0A031
`define QCC_IDX_LVL0 20'h0A032
`define QCC_IDX_LVL1 20'h0A033
`define QCC_IDX_IRQ_ST 20'h0A0F0
`define QCC_IDX_IRQ_CLR 20'h0A0F1
`define QCC_IDX_IRQ_EN 20'h0A0F2
`define QCC_ADR(idx) ({idx[17:0], 2'b00})

// config nibble bit positions within a channel nibble
`define QCC_F_ON 3
`define QCC_F_PICK 2
`define QCC_F_ALLOW 1
`define QCC_F_INV 0
// status register layout
`define QCC_ST_FLAG_LSB 4
`define QCC_ST_HYSB_LSB 2
`define QCC_ST_HYSA_LSB 0

`define QCC_RST_BYTE 8'h00
`define QCC_RST_IRQ_EN 4'hF
`define QCC_RST_WORD 32'h00000000

`endif

// [rtl/qcc_pkg.sv]
`include "qcc_params.svh"

package qcc_pkg;

	typedef enum logic [1:0] {
		SRC_LEVEL0,
		SRC_LEVEL1,
		SRC_EXT
	} qcc_src_e;

	typedef enum logic [1:0] {
		HYST_OFF,
		HYST_10MV,
		HYST_20MV,
		HYST_30MV
	} qcc_hyst_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`QCC_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} qcc_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} qcc_apb_rsp_s;

	// control seen by the analog comparators and threshold DACs
	typedef struct packed {
		logic [3:0] on;
		qcc_src_e [3:0] src;
		logic [3:0][1:0] pin_sel;
		qcc_hyst_e hyst_a;
		qcc_hyst_e hyst_bcd;
		logic [7:0] level0;
		logic [7:0] level1;
	} qcc_ana_s;

	typedef struct packed {
		logic [7:0] cfg_ab;
		logic [7:0] cfg_cd;
		logic [3:0] flags;
		logic [3:0] irq_en;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] live;
		logic [3:0] en_prev;
		logic irq;
		qcc_apb_rsp_s rsp;
		qcc_ana_s ana;
	} qcc_state_s;

endpackage

// [rtl/qcc_top.sv]
// Overview of operation
// - A/B config: enable, pick, irq allow, invert
// - C/D config uses the same nibble layout
// - channel A picks level zero or one
// - channels B-D pick level zero or external
// - invert bit flips comparator output sense
// - live status bits, forced low when disabled
// - toggle flags set on live change while enabled
// - flags stay until software clears them
// - both edges of each output are detected
// - irq needs allow bit and flag set
// - level zero register drives 8-bit DAC code
// - level one register drives second DAC code
// - status writes set hysteresis codes
// - hysteresis codes off, 10mV, 20mV, 30mV
// - comparators A and D share one pin
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module qcc_top
	import qcc_pkg::*;
(
	input wire logic CLOCK_I, // system clock, 100 MHz
	input wire logic RST_B_I, // async reset, active low
	input wire qcc_apb_req_s APB_REQ_I, // apb request
	output qcc_apb_rsp_s APB_RSP_O, // apb answer
	input wire logic [3:0] CMP_RAW_I, // async comparator outs, D..A
	output qcc_ana_s ANA_O, // analog control
	output logic IRQ_O // level interrupt
);

	qcc_state_s r_reg;
	qcc_state_s r_next;

	// channel nibble {on, pick, allow, invert}; 0=A .. 3=D
	function automatic logic [3:0] chan_cfg(input logic [7:0] ab,
		input logic [7:0] cd, input logic [1:0] ch);
		logic [3:0] n;
		n = 4'h0;
		case (ch)
			2'd0: n = ab[7:4];
			2'd1: n = ab[3:0];
			2'd2: n = cd[7:4];
			default: n = cd[3:0];
		endcase
		return n;
	endfunction

	function automatic logic hit(input logic [`QCC_ADDR_W-1:0] a,
		input logic [`QCC_ADDR_W-1:0] idx);
		return a == `QCC_ADR(idx);
	endfunction

	logic setup;
	logic acc;
	logic wr;
	logic [7:0] wb;
	logic [`QCC_ADDR_W-1:0] ad;
	logic [3:0] tog;
	logic [3:0] clr;
	logic [3:0] on;
	logic [3:0] pick;
	logic [3:0] allow;
	logic [3:0] inv;
	logic [3:0] live_n;
	logic [3:0] nib;
	logic mapped;

	always_comb begin
		r_next = r_reg;
		ad = APB_REQ_I.paddr;
		wb = APB_REQ_I.pwdata[7:0];
		setup = APB_REQ_I.psel & ~APB_REQ_I.penable;
		acc = APB_REQ_I.psel & APB_REQ_I.penable & r_reg.rsp.pready;
		wr = acc & APB_REQ_I.pwrite & ~r_reg.rsp.pslverr;
		nib = 4'h0;
		for (int i = 0; i < 4; i++) begin
			nib = chan_cfg(r_reg.cfg_ab, r_reg.cfg_cd, 2'(i));
			on[i] = nib[`QCC_F_ON];
			pick[i] = nib[`QCC_F_PICK];
			allow[i] = nib[`QCC_F_ALLOW];
			inv[i] = nib[`QCC_F_INV];
		end
		// two-stage synchroniser
		r_next.sync1 = CMP_RAW_I;
		r_next.sync2 = r_reg.sync1;
		live_n = on & (r_reg.sync2 ^ inv);
		r_next.live = live_n;
		r_next.en_prev = on;
		// any edge of an enabled output
		tog = (live_n ^ r_reg.live) & on & r_reg.en_prev;
		clr = 4'h0;
		// register writes
		if (wr) begin
			if (hit(ad, `QCC_IDX_AB))
				r_next.cfg_ab = wb;
			if (hit(ad, `QCC_IDX_CD))
				r_next.cfg_cd = wb;
			if (hit(ad, `QCC_IDX_LVL0))
				r_next.ana.level0 = wb;
			if (hit(ad, `QCC_IDX_LVL1))
				r_next.ana.level1 = wb;
			if (hit(ad, `QCC_IDX_STAT)) begin
				clr = wb[7:4];
				r_next.ana.hyst_bcd = qcc_hyst_e'(wb[3:2]);
				r_next.ana.hyst_a = qcc_hyst_e'(wb[1:0]);
			end
			if (hit(ad, `QCC_IDX_IRQ_CLR))
				clr = wb[3:0];
			if (hit(ad, `QCC_IDX_IRQ_EN))
				r_next.irq_en = wb[3:0];
		end
		// set wins over a simultaneous clear
		r_next.flags = (r_reg.flags & ~clr) | tog;
		r_next.irq = |(r_reg.flags & allow & r_reg.irq_en);
		// analog control, from the registered config
		r_next.ana.on = on;
		r_next.ana.src[0] = pick[0] ? SRC_LEVEL1 : SRC_LEVEL0;
		for (int i = 1; i < 4; i++)
			r_next.ana.src[i] = pick[i] ? SRC_EXT : SRC_LEVEL0;
		r_next.ana.pin_sel[0] = 2'd0;
		r_next.ana.pin_sel[1] = 2'd1;
		r_next.ana.pin_sel[2] = 2'd2;
		r_next.ana.pin_sel[3] = 2'd0;
		// apb: answer in the first access cycle
		mapped = hit(ad, `QCC_IDX_STAT) | hit(ad, `QCC_IDX_AB)
			| hit(ad, `QCC_IDX_CD) | hit(ad, `QCC_IDX_LVL0)
			| hit(ad, `QCC_IDX_LVL1) | hit(ad, `QCC_IDX_IRQ_ST)
			| hit(ad, `QCC_IDX_IRQ_CLR) | hit(ad, `QCC_IDX_IRQ_EN);
		r_next.rsp.pready = setup;
		r_next.rsp.pslverr = setup & ~mapped;
		r_next.rsp.prdata = `QCC_RST_WORD;
		if (setup & ~APB_REQ_I.pwrite) begin
			if (hit(ad, `QCC_IDX_STAT))
				r_next.rsp.prdata[7:0] = {r_reg.flags, r_reg.live};
			if (hit(ad, `QCC_IDX_AB))
				r_next.rsp.prdata[7:0] = r_reg.cfg_ab;
			if (hit(ad, `QCC_IDX_CD))
				r_next.rsp.prdata[7:0] = r_reg.cfg_cd;
			if (hit(ad, `QCC_IDX_LVL0))
				r_next.rsp.prdata[7:0] = r_reg.ana.level0;
			if (hit(ad, `QCC_IDX_LVL1))
				r_next.rsp.prdata[7:0] = r_reg.ana.level1;
			if (hit(ad, `QCC_IDX_IRQ_ST))
				r_next.rsp.prdata[3:0] = r_reg.flags;
			if (hit(ad, `QCC_IDX_IRQ_EN))
				r_next.rsp.prdata[3:0] = r_reg.irq_en;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			r_reg <= '0;
			r_reg.irq_en <= `QCC_RST_IRQ_EN;
			r_reg.ana.pin_sel <= {2'd0, 2'd2, 2'd1, 2'd0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign APB_RSP_O = r_reg.rsp;
	assign ANA_O = r_reg.ana;
	assign IRQ_O = r_reg.irq;

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_B_I);

	logic wr_ab;
	logic wr_cd;
	logic wr_l0;
	logic wr_st;
	assign wr_ab = wr & hit(ad, `QCC_IDX_AB);
	assign wr_cd = wr & hit(ad, `QCC_IDX_CD);
	assign wr_l0 = wr & hit(ad, `QCC_IDX_LVL0);
	assign wr_st = wr & hit(ad, `QCC_IDX_STAT);

	AST_AB_STORE: assert property (wr_ab |=>
		r_reg.cfg_ab == $past(APB_REQ_I.pwdata[7:0]))
		else $error("ab config not stored");
	AST_CD_ON: assert property (wr_cd ##1 1 |=>
		ANA_O.on[3] == $past(APB_REQ_I.pwdata[3], 2))
		else $error("channel D enable wrong");
	AST_SRC_A: assert property (1 |=>
		ANA_O.src[0] == ($past(r_reg.cfg_ab[6]) ? SRC_LEVEL1 : SRC_LEVEL0))
		else $error("channel A source wrong");
	AST_SRC_B: assert property (1 |=>
		ANA_O.src[1] == ($past(r_reg.cfg_ab[2]) ? SRC_EXT : SRC_LEVEL0))
		else $error("channel B source wrong");
	AST_POL_A: assert property (r_reg.cfg_ab[7] |=>
		r_reg.live[0] == ($past(r_reg.sync2[0]) ^ $past(r_reg.cfg_ab[4])))
		else $error("channel A polarity wrong");
	AST_OFF_LOW: assert property (!r_reg.cfg_cd[7] |=>
		!r_reg.live[2])
		else $error("disabled channel C live high");
	AST_TOGGLE: assert property (tog[1] |=> r_reg.flags[1])
		else $error("toggle did not set flag B");
	AST_STICKY: assert property ((r_reg.flags[0] && !wr) |=>
		r_reg.flags[0])
		else $error("flag A dropped without clear");
	AST_IRQ: assert property (1 |=> IRQ_O ==
		$past(|(r_reg.flags & allow & r_reg.irq_en)))
		else $error("irq level wrong");
	AST_LEVEL0: assert property (wr_l0 |=>
		ANA_O.level0 == $past(APB_REQ_I.pwdata[7:0]))
		else $error("level zero not stored");
	AST_HYST: assert property (wr_st |=>
		ANA_O.hyst_bcd == qcc_hyst_e'($past(APB_REQ_I.pwdata[3:2])))
		else $error("hysteresis code not stored");
	AST_PIN: assert property (ANA_O.pin_sel[0] == ANA_O.pin_sel[3])
		else $error("A and D pins differ");
	AST_SYNC: assert property (1 ##2 1 |->
		r_reg.sync2 == $past(CMP_RAW_I, 2))
		else $error("synchroniser depth wrong");
	AST_ANSWER: assert property (setup |=> APB_RSP_O.pready ##1
		!APB_RSP_O.pready)
		else $error("apb answer timing wrong");

	COV_FLAG: cover property (tog[0] ##1 r_reg.flags[0]);
	COV_IRQ: cover property ($rose(IRQ_O));
	COV_CLR: cover property (wr_st && r_reg.flags != 4'h0);
	COV_ERR: cover property (APB_RSP_O.pslverr);

endmodule

// [verif/qcc_ana_model.sv]
`timescale 1ns/10ps
module qcc_ana_model
	import qcc_pkg::*;
(
	input wire qcc_ana_s ana_i, // control from block
	input wire logic [2:0][7:0] pin_i, // pin levels as codes
	input wire logic [7:0] ext_i, // external threshold
	output logic [3:0] raw_o // comparator outputs D..A
);
	logic [3:0][7:0] thr;
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			case (ana_i.src[c])
				SRC_LEVEL0: thr[c] = ana_i.level0;
				SRC_LEVEL1: thr[c] = ana_i.level1;
				default: thr[c] = ext_i;
			endcase
			// runs even when disabled, block must mask it
			raw_o[c] = pin_i[ana_i.pin_sel[c]] > thr[c];
		end
	end
endmodule

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
	import qcc_pkg::*;
	logic clock_i = 0;
	logic rst_b_i = 0;
	qcc_apb_req_s req = '0;
	qcc_apb_rsp_s rsp;
	qcc_ana_s ana;
	logic [3:0] raw;
	logic irq;
	logic [2:0][7:0] pin = '0;
	logic [7:0] ext = 8'h00;
	logic [7:0] rd;
	logic er;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	qcc_top u_dut (.CLOCK_I(clock_i), .RST_B_I(rst_b_i), .APB_REQ_I(req),
		.APB_RSP_O(rsp), .CMP_RAW_I(raw), .ANA_O(ana), .IRQ_O(irq));
	qcc_ana_model u_ana (.ana_i(ana), .pin_i(pin), .ext_i(ext), .raw_o(raw));
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	task end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] x, input string nm);
		cmp_count++;
		if (s !== x) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask
	task apb(input logic w, input logic [19:0] i, input logic [7:0] d);
		@(posedge clock_i);
		req <= '{1'b1, 1'b0, w, {i[17:0], 2'b00}, {24'h0, d}};
		@(posedge clock_i);
		req.penable <= 1'b1;
		do @(posedge clock_i); while (rsp.pready !== 1'b1);
		rd = rsp.prdata[7:0];
		er = rsp.pslverr;
		req <= '0;
	endtask
	task rchk(input logic [19:0] i, input logic [7:0] x, input string nm);
		apb(0, i, 8'h00);
		chk(rd, x, nm);
	endtask
	task wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task t_reset();
		logic [19:0] idx [5] = '{20'h00094, 20'h0A030, 20'h0A031,
			20'h0A032, 20'h0A033};
		foreach (idx[k]) rchk(idx[k], 8'h00, "reset value");
		chk(ana.pin_sel, 8'h24, "pin_sel");
		chk(irq, 1'b0, "irq reset");
		apb(0, 20'h00010, 8'h00);
		chk({er, rd}, 9'h100, "unmapped");
		$display("t_reset done");
	endtask
	task t_cfg();
		apb(1, 20'h0A030, 8'hC8);
		apb(1, 20'h0A031, 8'hAC);
		apb(1, 20'h0A032, 8'h00);
		apb(1, 20'h0A033, 8'hFF);
		rchk(20'h0A030, 8'hC8, "ab cfg");
		rchk(20'h0A031, 8'hAC, "cd cfg");
		rchk(20'h0A033, 8'hFF, "level1");
		chk(ana.on, 4'hF, "on");
		chk(ana.src, 8'h81, "src");
		chk({ana.level0, ana.level1}, 16'h00FF, "dac codes");
		wt(2000);
		$display("t_cfg done");
	endtask
	task t_live();
		pin <= {8'h00, 8'h10, 8'h80};
		ext <= 8'h40;
		wt(8);
		rchk(20'h00094, 8'hAA, "live and flags");
		chk(irq, 1'b0, "irq not allowed");
		apb(1, 20'h00094, 8'hF9);
		wt(3);
		rchk(20'h00094, 8'h0A, "flags cleared");
		chk({ana.hyst_a, ana.hyst_bcd}, {HYST_10MV, HYST_20MV}, "hyst");
		$display("t_live done");
	endtask
	task t_irq();
		pin[2] <= 8'h20;
		wt(8);
		chk(irq, 1'b1, "irq rise");
		wt(20);
		rchk(20'h00094, 8'h4E, "sticky flag");
		rchk(20'h0A0F0, 8'h04, "irq status");
		apb(1, 20'h0A0F2, 8'h00);
		wt(3);
		chk(irq, 1'b0, "irq masked");
		apb(1, 20'h0A0F2, 8'h0F);
		wt(3);
		chk(irq, 1'b1, "irq unmasked");
		apb(1, 20'h0A0F1, 8'h04);
		wt(3);
		chk(irq, 1'b0, "irq cleared");
		pin[2] <= 8'h00;
		wt(8);
		rchk(20'h00094, 8'h4A, "fall flag");
		apb(1, 20'h00094, 8'h4F);
		wt(3);
		chk(irq, 1'b0, "status clear");
		chk({ana.hyst_a, ana.hyst_bcd}, {HYST_30MV, HYST_30MV}, "hyst3");
		$display("t_irq done");
	endtask
	task t_off();
		apb(1, 20'h0A031, 8'hA4);
		wt(8);
		rchk(20'h00094, 8'h02, "disabled forced low");
		apb(1, 20'h0A030, 8'hD8);
		wt(8);
		rchk(20'h00094, 8'h13, "inverted");
		chk(ana.on, 4'h7, "on after off");
		$display("t_off done");
	endtask
	initial begin
		wt(10);
		rst_b_i <= 1'b1;
		t_reset();
		t_cfg();
		t_live();
		t_irq();
		t_off();
		end_of_test();
	end
endmodule
